// ==== hdl/nibble_core_defs.svh ====
// constants for the nibble core exchange and operand logic
`ifndef NIBBLE_CORE_DEFS_SVH
`define NIBBLE_CORE_DEFS_SVH

// widths and depths
`define PC_W 11
`define DADDR_W 9
`define ROM_DEPTH 2048
`define RAM_DEPTH 512

// sys_clk periods in one machine cycle
`define MCYC_CLKS 6'h08

// data memory bank 0 locations
`define IRQEN_ADDR 8'h7C
`define IRQEN_BIT 0
`define FRAME_LO_ADDR 8'h7E
`define FRAME_HI_ADDR 8'h7F
`define BANK_ZERO 1'h0

// reset values
`define PC_RESET 11'h000
`define NIB_RESET 4'h0

// whole-byte opcodes
`define OP_NOP 8'h00
`define OP_LOAD_PRI 8'h30
`define OP_LOAD_SEC 8'h31
`define OP_SWAP_NIB 8'h40
`define OP_SWAP_NIB_SEC 8'h41
`define OP_BYTE_SWAP 8'h42
`define OP_BYTE_SWAP_SEC 8'h43
`define OP_DIRECT_NIB_SWAP 8'h44
`define OP_DIRECT_BYTE_SWAP 8'h45
`define OP_SWAP_INC 8'h46
`define OP_SWAP_DEC 8'h47
`define OP_STACK_PEEK 8'h48

// opcode groups matched on their upper bits
`define OP_LOAD_A 4'h1
`define OP_LOAD_B 4'h2
`define OP_BIT_TEST 6'h14
`define OP_TABLE_LOAD 5'h0C
`define OP_JUMP 5'h0E

`endif

// ==== hdl/nibble_core_pkg.sv ====
// types shared by the nibble core files
package nibble_core_pkg;

    // what an opcode does
    typedef enum logic [3:0] {
        K_NOP, K_LOAD_A, K_LOAD_B, K_LOAD_PRI, K_LOAD_SEC, K_SWAP_NIB, K_SWAP_BYTE,
        K_SWAP_INC, K_SWAP_DEC, K_STACK_PEEK, K_BIT_TEST, K_TABLE, K_JUMP
    } kind_t;

    // sequencer states
    typedef enum logic [3:0] {
        S_FETCH1, S_FETCH1W, S_FETCH2, S_FETCH2W, S_ADDR, S_RD0, S_RD0W,
        S_RD1, S_RD1W, S_EXE, S_WR0, S_WR1, S_PAD
    } state_t;

    // decoded opcode
    typedef struct packed {
        kind_t kind;
        logic [1:0] bytes;
        logic [2:0] cycles;
        logic use_sec;
        logic direct;
    } decode_t;

    // working registers
    typedef struct packed {
        logic [3:0] a;
        logic [3:0] b;
        logic [3:0] h;
        logic [3:0] l;
        logic [3:0] x;
        logic [3:0] y;
    } regs_t;

endpackage

// ==== hdl/nibble_ram.sv ====
// nibble-wide data memory with registered read data
`timescale 1ns/10ps
`include "nibble_core_defs.svh"
module nibble_ram (
    input wire logic sys_clk,
    input wire logic [`DADDR_W-1:0] addr,
    input wire logic we,
    input wire logic [3:0] wdata,
    output logic [3:0] rdata
);
    // storage, contents undefined at power up
    logic [3:0] mem [0:`RAM_DEPTH-1];
    logic [3:0] rdata_nxt;

    // read of the addressed nibble
    always_comb begin
        rdata_nxt = mem[addr];
    end

    // write port and read register
    always_ff @(posedge sys_clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= rdata_nxt;
    end
endmodule

// ==== hdl/prog_rom.sv ====
// byte-wide program memory, loadable, registered read data
`timescale 1ns/10ps
`include "nibble_core_defs.svh"
module prog_rom (
    input wire logic sys_clk,
    input wire logic [`PC_W-1:0] raddr,
    output logic [7:0] rdata,
    input wire logic load_we,
    input wire logic [`PC_W-1:0] load_addr,
    input wire logic [7:0] load_data
);
    // program storage
    logic [7:0] mem [0:`ROM_DEPTH-1];
    logic [7:0] rdata_nxt;

    // read of the addressed byte
    always_comb begin
        rdata_nxt = mem[raddr];
    end

    // load port and read register
    always_ff @(posedge sys_clk) begin
        if (load_we) begin
            mem[load_addr] <= load_data;
        end
        rdata <= rdata_nxt;
    end
endmodule

// ==== hdl/nibble_core.sv ====
// nibble core sequencer for memory exchange and operand handling
`timescale 1ns/10ps
`include "nibble_core_defs.svh"
module nibble_core
    import nibble_core_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic run,
    input wire logic dmem_bank,
    input wire logic prog_we,
    input wire logic [`PC_W-1:0] prog_addr,
    input wire logic [7:0] prog_data,
    output logic [`PC_W-1:0] pc,
    output regs_t work_regs,
    output logic master_irq_enable,
    output logic [7:0] call_frame_pointer,
    output logic [7:0] pushed_byte,
    output logic instr_done,
    output logic skip_active
);
    // sequencer state
    state_t state_r, state_nxt;
    logic [5:0] cnt_r, cnt_nxt;          // clocks into the instruction
    logic [5:0] total_r, total_nxt;      // clocks the instruction takes
    logic [7:0] op_r, op_nxt;            // first code byte
    logic [7:0] imm_r, imm_nxt;          // second code byte
    logic [`PC_W-1:0] pc_r, pc_nxt;      // program counter
    regs_t regs_r, regs_nxt;             // working registers
    logic [7:0] addr0_r, addr0_nxt;      // first nibble address
    logic [7:0] addr1_r, addr1_nxt;      // second nibble address
    logic bank_r, bank_nxt;              // bank of this access
    logic [7:0] d0_r, d0_nxt;            // first read data
    logic [3:0] d1_r, d1_nxt;            // second read data
    logic [3:0] wd0_r, wd0_nxt;          // first write data
    logic [3:0] wd1_r, wd1_nxt;          // second write data
    logic skip_r, skip_nxt;              // next instruction is skipped
    logic skipping_r, skipping_nxt;      // current instruction is skipped
    logic irqen_r, irqen_nxt;            // shadow of irq enable bit
    logic [7:0] frame_r, frame_nxt;      // shadow of frame pointer
    logic [7:0] pushed_r, pushed_nxt;    // last stacked byte read
    logic done_r, done_nxt;              // instruction end pulse
    logic [7:0] pri_ptr;                 // primary pointer
    logic [7:0] sec_ptr;                 // secondary pointer
    decode_t dec;                        // decode of op_r
    decode_t dec_f;                      // decode of fetched byte
    logic [`PC_W-1:0] rom_addr;
    logic [7:0] rom_q;
    logic [`DADDR_W-1:0] ram_addr;
    logic ram_we;
    logic [3:0] ram_wd;
    logic [3:0] ram_q;
    logic [7:0] base;
    logic [3:0] l_step;

    // length, time and addressing of each opcode
    function automatic decode_t decode(input logic [7:0] op);
        decode_t d;
        d = '{kind: K_NOP, bytes: 2'h1, cycles: 3'h1, use_sec: 1'b0, direct: 1'b0};
        if (op[7:4] == `OP_LOAD_A) begin
            d.kind = K_LOAD_A;
        end else if (op[7:4] == `OP_LOAD_B) begin
            d.kind = K_LOAD_B;
        end else if (op[7:2] == `OP_BIT_TEST) begin
            d.kind = K_BIT_TEST;
        end else if (op[7:3] == `OP_TABLE_LOAD) begin
            d = '{kind: K_TABLE, bytes: 2'h2, cycles: 3'h3, use_sec: 1'b1, direct: 1'b0};
        end else if (op[7:3] == `OP_JUMP) begin
            d = '{kind: K_JUMP, bytes: 2'h2, cycles: 3'h2, use_sec: 1'b0, direct: 1'b0};
        end else begin
            case (op)
                `OP_LOAD_PRI: begin
                    d = '{kind: K_LOAD_PRI, bytes: 2'h2, cycles: 3'h2, use_sec: 1'b0, direct: 1'b0};
                end
                `OP_LOAD_SEC: begin
                    d = '{kind: K_LOAD_SEC, bytes: 2'h2, cycles: 3'h2, use_sec: 1'b0, direct: 1'b0};
                end
                `OP_SWAP_NIB: begin
                    d.kind = K_SWAP_NIB;
                end
                `OP_SWAP_NIB_SEC: begin
                    d = '{kind: K_SWAP_NIB, bytes: 2'h2, cycles: 3'h2, use_sec: 1'b1, direct: 1'b0};
                end
                `OP_BYTE_SWAP: begin
                    d = '{kind: K_SWAP_BYTE, bytes: 2'h1, cycles: 3'h2, use_sec: 1'b0, direct: 1'b0};
                end
                `OP_BYTE_SWAP_SEC: begin
                    d = '{kind: K_SWAP_BYTE, bytes: 2'h2, cycles: 3'h3, use_sec: 1'b1, direct: 1'b0};
                end
                `OP_DIRECT_NIB_SWAP: begin
                    d = '{kind: K_SWAP_NIB, bytes: 2'h2, cycles: 3'h2, use_sec: 1'b0, direct: 1'b1};
                end
                `OP_DIRECT_BYTE_SWAP: begin
                    d = '{kind: K_SWAP_BYTE, bytes: 2'h2, cycles: 3'h2, use_sec: 1'b0, direct: 1'b1};
                end
                `OP_SWAP_INC: begin
                    d = '{kind: K_SWAP_INC, bytes: 2'h1, cycles: 3'h2, use_sec: 1'b0, direct: 1'b0};
                end
                `OP_SWAP_DEC: begin
                    d = '{kind: K_SWAP_DEC, bytes: 2'h1, cycles: 3'h2, use_sec: 1'b0, direct: 1'b0};
                end
                `OP_STACK_PEEK: begin
                    d = '{kind: K_STACK_PEEK, bytes: 2'h1, cycles: 3'h2, use_sec: 1'b0, direct: 1'b0};
                end
                default: begin
                    d.kind = K_NOP;
                end
            endcase
        end
        return d;
    endfunction

    // pointer pairs
    assign pri_ptr = {regs_r.h, regs_r.l};
    assign sec_ptr = {regs_r.x, regs_r.y};
    assign dec = decode(op_r);
    assign dec_f = decode(rom_q);

    // program memory
    prog_rom u_rom (
        .sys_clk(sys_clk),
        .raddr(rom_addr),
        .rdata(rom_q),
        .load_we(prog_we),
        .load_addr(prog_addr),
        .load_data(prog_data)
    );

    // data memory
    nibble_ram u_ram (
        .sys_clk(sys_clk),
        .addr(ram_addr),
        .we(ram_we),
        .wdata(ram_wd),
        .rdata(ram_q)
    );

    // sequencer next values
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r + 6'h01;
        total_nxt = total_r;
        op_nxt = op_r;
        imm_nxt = imm_r;
        pc_nxt = pc_r;
        regs_nxt = regs_r;
        addr0_nxt = addr0_r;
        addr1_nxt = addr1_r;
        bank_nxt = bank_r;
        d0_nxt = d0_r;
        d1_nxt = d1_r;
        wd0_nxt = wd0_r;
        wd1_nxt = wd1_r;
        skip_nxt = skip_r;
        skipping_nxt = skipping_r;
        pushed_nxt = pushed_r;
        done_nxt = 1'b0;
        rom_addr = pc_r;
        ram_addr = {bank_r, addr0_r};
        ram_we = 1'b0;
        ram_wd = wd0_r;
        base = dec.use_sec ? sec_ptr : pri_ptr;
        l_step = regs_r.l;
        case (state_r)
            S_FETCH1: begin
                // hold here while stopped
                cnt_nxt = run ? 6'h01 : 6'h00;
                if (run) begin
                    state_nxt = S_FETCH1W;
                end
            end
            S_FETCH1W: begin
                op_nxt = rom_q;
                pc_nxt = pc_r + 11'h001;
                total_nxt = 6'(dec_f.cycles * `MCYC_CLKS);
                state_nxt = (dec_f.bytes == 2'h2) ? S_FETCH2 : S_ADDR;
            end
            S_FETCH2: begin
                state_nxt = S_FETCH2W;
            end
            S_FETCH2W: begin
                imm_nxt = rom_q;
                pc_nxt = pc_r + 11'h001;
                state_nxt = S_ADDR;
            end
            S_ADDR: begin
                bank_nxt = dmem_bank;
                if (dec.direct) begin
                    base = imm_r;
                end
                if (skip_r) begin
                    // burn the time only
                    skip_nxt = 1'b0;
                    skipping_nxt = 1'b1;
                    state_nxt = S_PAD;
                end else begin
                    state_nxt = S_RD0;
                    case (dec.kind)
                        K_SWAP_BYTE: begin
                            addr0_nxt = {base[7:1], 1'b0};
                            addr1_nxt = {base[7:1], 1'b1};
                        end
                        K_STACK_PEEK: begin
                            bank_nxt = `BANK_ZERO;
                            addr0_nxt = frame_r;
                            addr1_nxt = frame_r - 8'h01;
                        end
                        K_TABLE: begin
                            addr0_nxt = {pri_ptr[7:1], 1'b0};
                            addr1_nxt = {pri_ptr[7:1], 1'b1};
                        end
                        K_SWAP_NIB, K_SWAP_INC, K_SWAP_DEC, K_BIT_TEST: begin
                            addr0_nxt = base;
                        end
                        default: begin
                            state_nxt = S_EXE;
                        end
                    endcase
                end
            end
            S_RD0: begin
                rom_addr = {op_r[2:0], sec_ptr};
                state_nxt = S_RD0W;
            end
            S_RD0W: begin
                // table byte from program memory, else a nibble
                d0_nxt = (dec.kind == K_TABLE) ? rom_q : {4'h0, ram_q};
                ram_addr = {bank_r, addr1_r};
                state_nxt = S_EXE;
                if (dec.kind == K_SWAP_BYTE || dec.kind == K_STACK_PEEK) begin
                    state_nxt = S_RD1;
                end
            end
            S_RD1: begin
                ram_addr = {bank_r, addr1_r};
                state_nxt = S_RD1W;
            end
            S_RD1W: begin
                d1_nxt = ram_q;
                state_nxt = S_EXE;
            end
            S_EXE: begin
                state_nxt = S_WR0;
                wd0_nxt = regs_r.a;
                wd1_nxt = regs_r.b;
                case (dec.kind)
                    K_LOAD_A: begin
                        regs_nxt.a = op_r[3:0];
                        state_nxt = S_PAD;
                    end
                    K_LOAD_B: begin
                        regs_nxt.b = op_r[3:0];
                        state_nxt = S_PAD;
                    end
                    K_LOAD_PRI: begin
                        {regs_nxt.h, regs_nxt.l} = imm_r;
                        state_nxt = S_PAD;
                    end
                    K_LOAD_SEC: begin
                        {regs_nxt.x, regs_nxt.y} = imm_r;
                        state_nxt = S_PAD;
                    end
                    K_SWAP_NIB: begin
                        regs_nxt.a = d0_r[3:0];
                    end
                    K_SWAP_BYTE: begin
                        // even nibble to A, odd nibble to B
                        regs_nxt.a = d0_r[3:0];
                        regs_nxt.b = d1_r;
                    end
                    K_SWAP_INC: begin
                        l_step = regs_r.l + 4'h1;
                        regs_nxt.a = d0_r[3:0];
                        regs_nxt.l = l_step;
                        skip_nxt = (l_step == 4'h0);
                    end
                    K_SWAP_DEC: begin
                        l_step = regs_r.l - 4'h1;
                        regs_nxt.a = d0_r[3:0];
                        regs_nxt.l = l_step;
                        skip_nxt = (l_step == 4'hF);
                    end
                    K_STACK_PEEK: begin
                        regs_nxt.b = d0_r[3:0];
                        regs_nxt.a = d1_r;
                        pushed_nxt = {d0_r[3:0], d1_r};
                        state_nxt = S_PAD;
                    end
                    K_BIT_TEST: begin
                        skip_nxt = d0_r[op_r[1:0]];
                        state_nxt = S_PAD;
                    end
                    K_TABLE: begin
                        wd0_nxt = d0_r[3:0];
                        wd1_nxt = d0_r[7:4];
                    end
                    K_JUMP: begin
                        pc_nxt = {op_r[2:0], imm_r};
                        state_nxt = S_PAD;
                    end
                    default: begin
                        state_nxt = S_PAD;
                    end
                endcase
            end
            S_WR0: begin
                ram_we = 1'b1;
                state_nxt = (dec.kind == K_SWAP_BYTE || dec.kind == K_TABLE) ? S_WR1 : S_PAD;
            end
            S_WR1: begin
                ram_addr = {bank_r, addr1_r};
                ram_we = 1'b1;
                ram_wd = wd1_r;
                state_nxt = S_PAD;
            end
            S_PAD: begin
                // wait out the machine cycles of the instruction
                if (cnt_r == total_r - 6'h01) begin
                    state_nxt = S_FETCH1;
                    cnt_nxt = 6'h00;
                    skipping_nxt = 1'b0;
                    done_nxt = 1'b1;
                end
            end
            default: begin
                state_nxt = S_FETCH1;
            end
        endcase
    end

    // shadows of bank 0 control locations follow every write there
    always_comb begin
        irqen_nxt = irqen_r;
        frame_nxt = frame_r;
        if (ram_we && ram_addr[`DADDR_W-1] == `BANK_ZERO) begin
            case (ram_addr[7:0])
                `IRQEN_ADDR: irqen_nxt = ram_wd[`IRQEN_BIT];
                `FRAME_LO_ADDR: frame_nxt[3:0] = ram_wd;
                `FRAME_HI_ADDR: frame_nxt[7:4] = ram_wd;
                default: irqen_nxt = irqen_r;
            endcase
        end
    end

    // register all state
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_r <= S_FETCH1;
            cnt_r <= 6'h00;
            total_r <= `MCYC_CLKS;
            op_r <= `OP_NOP;
            imm_r <= 8'h00;
            pc_r <= `PC_RESET;
            regs_r <= '0;
            addr0_r <= 8'h00;
            addr1_r <= 8'h00;
            bank_r <= `BANK_ZERO;
            d0_r <= 8'h00;
            d1_r <= `NIB_RESET;
            wd0_r <= `NIB_RESET;
            wd1_r <= `NIB_RESET;
            skip_r <= 1'b0;
            skipping_r <= 1'b0;
            irqen_r <= 1'b0;
            frame_r <= 8'h00;
            pushed_r <= 8'h00;
            done_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            total_r <= total_nxt;
            op_r <= op_nxt;
            imm_r <= imm_nxt;
            pc_r <= pc_nxt;
            regs_r <= regs_nxt;
            addr0_r <= addr0_nxt;
            addr1_r <= addr1_nxt;
            bank_r <= bank_nxt;
            d0_r <= d0_nxt;
            d1_r <= d1_nxt;
            wd0_r <= wd0_nxt;
            wd1_r <= wd1_nxt;
            skip_r <= skip_nxt;
            skipping_r <= skipping_nxt;
            irqen_r <= irqen_nxt;
            frame_r <= frame_nxt;
            pushed_r <= pushed_nxt;
            done_r <= done_nxt;
        end
    end

    // outputs straight from flops
    assign pc = pc_r;
    assign work_regs = regs_r;
    assign master_irq_enable = irqen_r;
    assign call_frame_pointer = frame_r;
    assign pushed_byte = pushed_r;
    assign instr_done = done_r;
    assign skip_active = skipping_r;

    // checks
    instr_length_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (state_r == S_PAD && state_nxt == S_FETCH1)
        |-> cnt_r == 6'(dec.cycles * `MCYC_CLKS) - 6'h01)
        else $error("instruction length wrong");
    byte_sec_time_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (state_r == S_FETCH1W && rom_q == `OP_BYTE_SWAP_SEC) |=> total_r == 6'h18)
        else $error("byte swap time wrong");
    pri_addr_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (state_r == S_RD0 && op_r == `OP_SWAP_NIB) |-> addr0_r == {regs_r.h, regs_r.l})
        else $error("primary pointer address wrong");
    sec_byte_addr_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (state_r == S_RD1 && op_r == `OP_BYTE_SWAP_SEC)
        |-> addr1_r == {regs_r.x, regs_r.y[3:1], 1'b1} && addr0_r[0] == 1'b0)
        else $error("secondary byte address wrong");
    direct_addr_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (state_r == S_RD0 && op_r == `OP_DIRECT_NIB_SWAP) |-> addr0_r == imm_r)
        else $error("direct address wrong");
    inc_skip_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (state_r == S_EXE && op_r == `OP_SWAP_INC && regs_r.l == 4'hF)
        |=> skip_r && regs_r.l == 4'h0)
        else $error("increment wrap skip missing");
    dec_skip_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (state_r == S_EXE && op_r == `OP_SWAP_DEC) |=> skip_r == (regs_r.l == 4'hF))
        else $error("decrement skip wrong");
    skip_quiet_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        skipping_r |-> !ram_we && $stable(regs_r))
        else $error("skipped instruction changed state");
    irq_shadow_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (ram_we && ram_addr == {`BANK_ZERO, `IRQEN_ADDR}) |=> irqen_r == $past(ram_wd[0]))
        else $error("irq enable shadow wrong");
    jump_load_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (state_r == S_EXE && dec.kind == K_JUMP) |=> pc_r == {$past(op_r[2:0]), $past(imm_r)})
        else $error("jump target wrong");
endmodule

// ==== testbench/prog_image.sv ====
// program memory image loader standing in for the program ROM contents
`timescale 1ns/10ps
`include "nibble_core_defs.svh"
module prog_image (
    input wire logic sys_clk,
    output logic prog_we,
    output logic [`PC_W-1:0] prog_addr,
    output logic [7:0] prog_data,
    output logic loaded
);
    // exchange, skip and jump program, one code byte per entry
    localparam logic [7:0] IMG [36] = '{8'h1F, 8'h27, 8'h45, 8'h7E, 8'h48, 8'h11, 8'h44,
        8'h7C, 8'h31, 8'h7C, 8'h10, 8'h43, 8'h00, 8'h30, 8'h2F, 8'h13, 8'h40, 8'h16,
        8'h46, 8'h1E, 8'h47, 8'h1E, 8'h40, 8'h30, 8'h20, 8'h51, 8'h1E, 8'h52, 8'h1D,
        8'h31, 8'h00, 8'h60, 8'h00, 8'h40, 8'h71, 8'h23};
    // one byte per falling edge, then flag the image as complete
    initial begin
        prog_we = 1'b0;
        prog_addr = '0;
        prog_data = 8'h00;
        loaded = 1'b0;
        for (int i = 0; i < 36; i++) begin
            @(negedge sys_clk);
            prog_we = 1'b1;
            prog_addr = 11'(i);
            prog_data = IMG[i];
        end
        @(negedge sys_clk);
        prog_we = 1'b0;
        prog_data = ~prog_data; // released bus shows no stale byte
        loaded = 1'b1;
    end
endmodule

// ==== testbench/nibble_cpu_exchange_and_operands_test.sv ====
// self-checking bench running an exchange program through the nibble core
`timescale 1ns/10ps
`include "nibble_core_defs.svh"
module nibble_cpu_exchange_and_operands_test;
    import nibble_core_pkg::*;
    logic sys_clk = 1'b0; // core clock
    logic sys_rst = 1'b1; // reset request
    logic run = 1'b0; // fetch enable
    logic dmem_bank = `BANK_ZERO; // bank 0 holds the pointer and flag
    logic prog_we, loaded; // loader strobe, image complete
    logic [`PC_W-1:0] prog_addr, pc; // load address, program counter
    logic [7:0] prog_data, call_frame_pointer, pushed_byte; // load byte and shadows
    regs_t work_regs; // working registers
    logic master_irq_enable, instr_done, skip_active; // flag shadow and status
    int num_errors = 0; // mismatches
    int comparisons = 0; // checks made
    int cyc = 0; // timeout counter
    logic skip_seen = 1'b0; // skipped time seen during the last step
    // expected machine cycles of each instruction in the image
    int cyc_t [27] = '{1, 1, 2, 2, 1, 2, 2, 1, 3, 2, 1, 1, 1, 2, 1, 2, 1, 1, 2, 1, 1, 1, 1, 2,
        3, 1, 2};
    always #5 sys_clk = ~sys_clk;
    prog_image u_prog_image (.sys_clk(sys_clk), .prog_we(prog_we), .prog_addr(prog_addr),
        .prog_data(prog_data), .loaded(loaded));
    nibble_core u_nibble_core (.sys_clk(sys_clk), .sys_rst(sys_rst), .run(run),
        .dmem_bank(dmem_bank), .prog_we(prog_we), .prog_addr(prog_addr),
        .prog_data(prog_data), .pc(pc), .work_regs(work_regs),
        .master_irq_enable(master_irq_enable), .call_frame_pointer(call_frame_pointer),
        .pushed_byte(pushed_byte), .instr_done(instr_done), .skip_active(skip_active));
    // counts, verdict and end of run
    task automatic final_report();
        $display("checks %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // one comparison, with a report line only on a mismatch
    task automatic chk(string what, logic [10:0] exp, logic [10:0] got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // wait for the next end of instruction and check its length in clocks
    task automatic step(int c);
        int n;
        n = 0;
        skip_seen = 1'b0;
        do begin
            @(posedge sys_clk);
            #1;
            n++;
            if (skip_active === 1'b1) skip_seen = 1'b1;
        end while (instr_done !== 1'b1 && n < 200);
        if (c != 0) chk("clocks", 11'(8 * c), 11'(n));
    endtask
    // hang guard
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            num_errors++;
            final_report();
        end
    end
    // main sequence
    initial begin
        repeat (16) @(posedge sys_clk);
        @(negedge sys_clk);
        sys_rst = 1'b0;
        chk("pc after reset", `PC_RESET, pc);
        wait (loaded === 1'b1);
        @(negedge sys_clk);
        run = 1'b1;
        for (int i = 0; i < 27; i++) begin
            step(i == 0 ? 0 : cyc_t[i]);
            chk("skip", (i == 14 || i == 16 || i == 20) ? 11'h001 : 11'h000, 11'(skip_seen));
            case (i)
                2: chk("frame ptr", 11'h07F, 11'(call_frame_pointer));
                3: begin
                    chk("pushed", 11'h07F, 11'(pushed_byte));
                    chk("a", 11'h00F, 11'(work_regs.a));
                end
                5: chk("irq en", 11'h001, 11'(master_irq_enable));
                8: begin
                    chk("irq en", 11'h000, 11'(master_irq_enable));
                    chk("a", 11'h001, 11'(work_regs.a));
                end
                13: begin
                    chk("l", 11'h000, 11'(work_regs.l));
                    chk("a", 11'h003, 11'(work_regs.a));
                end
                14: chk("a", 11'h003, 11'(work_regs.a));
                15: chk("l", 11'h00F, 11'(work_regs.l));
                17: chk("a", 11'h006, 11'(work_regs.a));
                20: chk("a", 11'h006, 11'(work_regs.a));
                22: chk("a", 11'h00D, 11'(work_regs.a));
                25: chk("a", 11'h00F, 11'(work_regs.a));
                26: chk("pc", 11'h123, pc);
                default: ;
            endcase
        end
        run = 1'b0;
        final_report();
    end
endmodule
